//--- verilog/pfs_pkg.sv
// package: register map, field layouts and carriers for the flow config block
package pfs_pkg;
  // sizes of the flow table and signature
  localparam int NF   = 8;
  localparam int NCH  = 2;
  localparam int NSIG = 16;
  localparam int NHDR = 32;
  localparam int AW   = 12;
  // register byte offsets
  localparam logic [11:0] OFS_CTRL   = 12'h000;
  localparam logic [11:0] OFS_STAGE  = 12'h004;
  localparam logic [11:0] OFS_STATUS = 12'h008;
  localparam logic [11:0] OFS_FLOW0  = 12'h020;
  localparam logic [11:0] OFS_MAP0   = 12'h060;
  localparam int          NMAPW      = 4;
  localparam int          MAP_LANE   = 8;
  // reset values
  localparam logic [31:0] CTRL_RST  = 32'h0000_0000;
  localparam logic [31:0] STAGE_RST = 32'h0000_0000;
  localparam logic [31:0] FLOW_RST  = 32'h0000_0000;
  localparam logic [5:0]  MAP_RST   = 6'h00;
  // byte map select codes
  localparam logic [5:0] SEL_HDR_LAST = 6'h17;
  localparam logic [5:0] SEL_HDR_TOP  = 6'h1F;
  localparam logic [5:0] SEL_HDR6     = 6'h18;
  localparam logic [5:0] SEL_HDR4     = 6'h19;
  localparam logic [5:0] SEL_HDR0     = 6'h1A;
  localparam logic [5:0] SEL_ADR0     = 6'h1C;
  localparam logic [5:0] SEL_ADR7     = 6'h23;
  // address source codes
  localparam logic [1:0] ASRC_FIRST_ETHERNET_COMPARATOR = 2'h0;
  localparam logic [1:0] ASRC_SECOND_ETHERNET_COMPARATOR = 2'h1;
  localparam logic [1:0] ASRC_IP1  = 2'h2;
  localparam logic [1:0] ASRC_IP2  = 2'h3;

  // per-flow word, bit 0 upward: pos, upd, cnt, rw_pos, cf_loc, ch, en, grp
  typedef struct packed {
    logic [1:0]     grp;
    logic           en;
    logic [NCH-1:0] ch;
    logic [7:0]     cf_loc;
    logic [7:0]     rw_pos;
    logic [3:0]     rw_cnt;
    logic           upd;
    logic [2:0]     pos;
  } pfs_flow_s;
  localparam int FLOW_W = $bits(pfs_flow_s);

  // common control word, bit 0 upward
  typedef struct packed {
    logic       ip2_use_da;
    logic       ip1_use_da;
    logic       second_ethernet_comparator_use_da;
    logic       first_ethernet_comparator_use_da;
    logic       strict;
    logic       first_ethernet_comparator_en;
    logic       engine_en;
    logic [1:0] addr_src;
    logic       cksum_sel;
  } pfs_ctrl_s;
  localparam int CTRL_W = $bits(pfs_ctrl_s);

  // directives handed to the rewriter per matched frame
  typedef struct packed {
    logic                  hit;
    logic                  stamp_all;
    logic [$clog2(NF)-1:0] flow;
    logic [8:0]            mod_ofs;
    logic [2:0]            mod_pos;
    logic                  upd;
    logic [3:0]            rw_cnt;
    logic [7:0]            rw_pos;
    logic [7:0]            cf_loc;
    logic                  cksum_sel;
  } pfs_rw_s;
endpackage : pfs_pkg

//--- verilog/pfs_flow_cfg.sv
// flow action/control registers and frame signature builder
//
// Implementation choices: the address map and register access over APB.
`timescale 1ns/1ps
`default_nettype none
module pfs_flow_cfg
  import pfs_pkg::*;
#(
  parameter bit OAM_ENGINE = 1'b1
) (
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [AW-1:0]         paddr,
  input  wire logic [31:0]           pwdata,
  output logic      [31:0]           prdata,
  output logic                       pready,
  output logic                       pslverr,
  input  wire logic                  pkt_busy,
  input  wire logic                  pkt_eval,
  input  wire logic                  pkt_chan,
  input  wire logic                  egress,
  input  wire logic                  part_b,
  input  wire logic [NF-1:0]         stage1_hit,
  input  wire logic [NF-1:0]         stage2_hit,
  input  wire logic [1:0]            prev_grp,
  input  wire logic [7:0]            frame_ofs,
  input  wire logic [NHDR*8-1:0]     hdr_bytes,
  input  wire logic [47:0]           first_ethernet_comparator_sa,
  input  wire logic [47:0]           first_ethernet_comparator_da,
  input  wire logic [47:0]           second_ethernet_comparator_sa,
  input  wire logic [47:0]           second_ethernet_comparator_da,
  input  wire logic [63:0]           ip1_sa,
  input  wire logic [63:0]           ip1_da,
  input  wire logic [63:0]           ip2_sa,
  input  wire logic [63:0]           ip2_da,
  output pfs_rw_s                    rw_out,
  output logic      [NSIG*8-1:0]     sig_out,
  output logic                       sig_valid
);

  // whole module state
  typedef struct packed {
    pfs_ctrl_s                ctrl;
    logic      [NF-1:0]       st1_en;
    pfs_flow_s [NF-1:0]       flow;
    logic      [NSIG-1:0][5:0] map;
    logic                     ap_engine;
    logic                     ap_first_ethernet_comparator;
    logic      [NF-1:0]       ap_flow;
    logic      [NF-1:0][NCH-1:0] ap_ch;
    logic                     pready;
    logic                     pslverr;
    logic      [31:0]         prdata;
    pfs_rw_s                  rw;
    logic      [NSIG*8-1:0]   sig;
    logic                     sig_valid;
  } pfs_state_s;

  pfs_state_s st_r;
  pfs_state_s st_nxt;

  // pick source or destination address of one comparator
  function automatic logic [63:0] pick_adr(input logic use_da,
                                           input logic [63:0] sa,
                                           input logic [63:0] da);
    pick_adr = use_da ? da : sa;
  endfunction : pick_adr

  // decode one signature byte selector
  function automatic logic [7:0] sig_byte(input logic [5:0] sel,
                                          input logic [NHDR*8-1:0] hdr,
                                          input logic [63:0] adr);
    logic [4:0] hidx;
    logic [2:0] aidx;
    hidx = 5'(SEL_HDR_TOP - sel);
    aidx = 3'(sel - SEL_ADR0);
    sig_byte = 8'h00;
    if (sel <= SEL_HDR_LAST) begin
      sig_byte = hdr[8*hidx +: 8];
    end else if (sel == SEL_HDR6) begin
      sig_byte = hdr[8*6 +: 8];
    end else if (sel == SEL_HDR4) begin
      sig_byte = hdr[8*4 +: 8];
    end else if (sel == SEL_HDR0) begin
      sig_byte = hdr[7:0];
    end else if (sel >= SEL_ADR0 && sel <= SEL_ADR7) begin
      sig_byte = adr[8*aidx +: 8];
    end
  endfunction : sig_byte

  // bus decode helpers, address source and match results
  logic        acc;
  logic        is_flow;
  logic        is_map;
  logic [2:0]  flow_idx;
  logic [1:0]  map_idx;
  logic [63:0] adr_sel;
  logic [NF-1:0] eligible;
  logic [NF-1:0] hits;
  logic [$clog2(NF)-1:0] win;
  logic        any_hit;

  assign acc      = psel && penable && !st_r.pready;
  assign is_flow  = paddr >= OFS_FLOW0 && paddr < OFS_FLOW0 + 12'(NF*4)
                    && paddr[1:0] == 2'b00;
  assign is_map   = paddr >= OFS_MAP0 && paddr < OFS_MAP0 + 12'(NMAPW*4)
                    && paddr[1:0] == 2'b00;
  assign flow_idx = 3'((paddr - OFS_FLOW0) >> 2);
  assign map_idx  = 2'((paddr - OFS_MAP0) >> 2);

  // address byte source for the signature
  always_comb begin
    adr_sel = 64'h0;
    unique case (st_r.ctrl.addr_src)
      ASRC_FIRST_ETHERNET_COMPARATOR: adr_sel = pick_adr(st_r.ctrl.first_ethernet_comparator_use_da,
                                    {16'h0000, first_ethernet_comparator_sa}, {16'h0000, first_ethernet_comparator_da});
      ASRC_SECOND_ETHERNET_COMPARATOR: adr_sel = pick_adr(st_r.ctrl.second_ethernet_comparator_use_da,
                                    {16'h0000, second_ethernet_comparator_sa}, {16'h0000, second_ethernet_comparator_da});
      ASRC_IP1:  adr_sel = pick_adr(st_r.ctrl.ip1_use_da, ip1_sa, ip1_da);
      ASRC_IP2:  adr_sel = pick_adr(st_r.ctrl.ip2_use_da, ip2_sa, ip2_da);
    endcase
    // part B has no second ethernet block
    if (OAM_ENGINE && part_b && st_r.ctrl.addr_src == ASRC_SECOND_ETHERNET_COMPARATOR) begin
      adr_sel = 64'h0;
    end
  end

  // per-flow match qualification on the applied enables and the live group field
  always_comb begin
    eligible = '0;
    hits     = '0;
    win      = '0;
    any_hit  = 1'b0;
    for (int i = 0; i < NF; i++) begin
      eligible[i] = st_r.ap_flow[i] && st_r.ap_ch[i][pkt_chan];
      // earlier ethernet stage checked only while it is enabled
      hits[i] = eligible[i] && stage2_hit[i]
                && (!st_r.ap_first_ethernet_comparator || stage1_hit[i]);
      // next-protocol group must have matched earlier
      if (OAM_ENGINE) begin
        hits[i] = hits[i] && ((st_r.flow[i].grp & prev_grp) != 2'b00);
      end
    end
    for (int i = NF - 1; i >= 0; i--) begin
      if (hits[i]) begin
        win     = ($clog2(NF))'(i);
        any_hit = 1'b1;
      end
    end
  end

  // next state: bus slave, apply-between-packets and evaluation
  always_comb begin
    st_nxt         = st_r;
    st_nxt.pready  = 1'b0;
    st_nxt.pslverr = 1'b0;
    st_nxt.sig_valid = 1'b0;
    st_nxt.rw.hit  = 1'b0;
    st_nxt.rw.stamp_all = 1'b0;
    // first access cycle: decode, capture read data, raise pready
    if (acc) begin
      st_nxt.pready = 1'b1;
      st_nxt.prdata = 32'h0;
      if (paddr == OFS_CTRL) begin
        st_nxt.prdata = 32'(st_r.ctrl);
      end else if (paddr == OFS_STAGE) begin
        st_nxt.prdata = 32'(st_r.st1_en);
      end else if (paddr == OFS_STATUS) begin
        st_nxt.prdata = {22'h0, pkt_busy, st_r.ap_engine, st_r.ap_flow};
      end else if (is_flow) begin
        st_nxt.prdata = 32'(st_r.flow[flow_idx]);
      end else if (is_map) begin
        for (int k = 0; k < NMAPW; k++) begin
          st_nxt.prdata[MAP_LANE*k +: 6] = st_r.map[NMAPW*map_idx + k];
        end
      end else begin
        st_nxt.pslverr = 1'b1;
      end
    end
    // completing edge: write takes effect
    if (psel && penable && st_r.pready && pwrite) begin
      if (paddr == OFS_CTRL) begin
        st_nxt.ctrl = pfs_ctrl_s'(pwdata[CTRL_W-1:0]);
      end else if (paddr == OFS_STAGE) begin
        // per-flow enable of the earlier stage
        st_nxt.st1_en = pwdata[NF-1:0];
      end else if (is_flow) begin
        st_nxt.flow[flow_idx] = pfs_flow_s'(pwdata[FLOW_W-1:0]);
      end else if (is_map) begin
        for (int k = 0; k < NMAPW; k++) begin
          st_nxt.map[NMAPW*map_idx + k] = pwdata[MAP_LANE*k +: 6];
        end
      end
    end
    // enables take effect only outside a packet
    if (!pkt_busy) begin
      st_nxt.ap_engine = st_r.ctrl.engine_en;
      st_nxt.ap_first_ethernet_comparator   = st_r.ctrl.first_ethernet_comparator_en;
      for (int i = 0; i < NF; i++) begin
        // strict mode needs the flow's earlier-stage enable set
        st_nxt.ap_flow[i] = st_r.flow[i].en
                            && (!st_r.ctrl.strict || st_r.st1_en[i])
                            && st_r.ctrl.engine_en;
        st_nxt.ap_ch[i] = st_r.flow[i].ch;
      end
    end
    // end of analysis: hand directives and signature onward
    if (pkt_eval && st_r.ap_engine) begin
      // first ethernet comparator off stamps every frame
      st_nxt.rw.stamp_all = !st_r.ap_first_ethernet_comparator;
      st_nxt.rw.hit       = any_hit;
      st_nxt.rw.flow      = win;
      // status byte position plus timing frame start
      st_nxt.rw.mod_pos   = st_r.flow[win].pos;
      st_nxt.rw.mod_ofs   = {1'b0, frame_ofs} + 9'(st_r.flow[win].pos);
      // update request for the modified-status bit
      st_nxt.rw.upd       = st_r.flow[win].upd;
      st_nxt.rw.rw_cnt    = st_r.flow[win].rw_cnt;
      st_nxt.rw.rw_pos    = st_r.flow[win].rw_pos;
      st_nxt.rw.cf_loc    = st_r.flow[win].cf_loc;
      st_nxt.rw.cksum_sel = st_r.ctrl.cksum_sel;
      if (egress && (any_hit || !st_r.ap_first_ethernet_comparator)) begin
        st_nxt.sig_valid = 1'b1;
        for (int b = 0; b < NSIG; b++) begin
          // byte b from its selector, byte 0 lowest
          st_nxt.sig[8*b +: 8] = sig_byte(st_r.map[b], hdr_bytes, adr_sel);
        end
      end
    end
  end

  // state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r.ctrl      <= pfs_ctrl_s'(CTRL_RST[CTRL_W-1:0]);
      st_r.st1_en    <= STAGE_RST[NF-1:0];
      st_r.flow      <= '{default: pfs_flow_s'(FLOW_RST[FLOW_W-1:0])};
      st_r.map       <= '{default: MAP_RST};
      st_r.ap_engine <= 1'b0;
      st_r.ap_first_ethernet_comparator   <= 1'b0;
      st_r.ap_flow   <= '0;
      st_r.ap_ch     <= '0;
      st_r.pready    <= 1'b0;
      st_r.pslverr   <= 1'b0;
      st_r.prdata    <= 32'h0;
      st_r.rw        <= '0;
      st_r.sig       <= '0;
      st_r.sig_valid <= 1'b0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // outputs straight from the state register
  assign prdata    = st_r.prdata;
  assign pready    = st_r.pready;
  assign pslverr   = st_r.pslverr;
  assign rw_out    = st_r.rw;
  assign sig_out   = st_r.sig;
  assign sig_valid = st_r.sig_valid;

endmodule : pfs_flow_cfg
`default_nettype wire

//--- verification/pfs_flow_cfg_sva.sv
// checker: bus timing and frame output relations of the flow block
`timescale 1ns/1ps
`default_nettype none
module pfs_flow_cfg_sva
  import pfs_pkg::*;
(
  input wire logic          pclk,
  input wire logic          presetn,
  input wire logic          psel,
  input wire logic          penable,
  input wire logic          pready,
  input wire logic          pslverr,
  input wire logic          pkt_eval,
  input wire logic          egress,
  input wire logic [7:0]    frame_ofs,
  input wire logic [NF-1:0] stage2_hit,
  input wire pfs_rw_s       rw_out,
  input wire logic          sig_valid
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [NF-1:0] s2_d;
  // hit vector of the evaluated frame
  always_ff @(posedge pclk) s2_d <= stage2_hit;
  property p_wait; psel && penable && !pready |=> pready; endproperty
  a_wait: assert property (p_wait) else $error("pready late");
  property p_pulse; pready |=> !pready; endproperty
  a_pulse: assert property (p_pulse) else $error("pready too long");
  property p_err; pslverr |-> pready; endproperty
  a_err: assert property (p_err) else $error("pslverr without pready");
  property p_hit; rw_out.hit |-> $past(pkt_eval) && s2_d[rw_out.flow];
  endproperty
  a_hit: assert property (p_hit) else $error("hit without cause");
  property p_ofs; rw_out.hit |->
    rw_out.mod_ofs == 9'($past(frame_ofs)) + 9'(rw_out.mod_pos); endproperty
  a_ofs: assert property (p_ofs) else $error("bad status offset");
  property p_sig; sig_valid |-> $past(egress && pkt_eval); endproperty
  a_sig: assert property (p_sig) else $error("signature off egress");
  property p_stamp; rw_out.stamp_all |-> $past(pkt_eval); endproperty
  a_stamp: assert property (p_stamp) else $error("stray stamp");
  property p_hold; !$past(pkt_eval) |->
    $stable(rw_out.rw_pos) && $stable(rw_out.cf_loc); endproperty
  a_hold: assert property (p_hold) else $error("fields moved");
  c_hit: cover property (rw_out.hit);
  c_sig: cover property (sig_valid);
  c_err: cover property (pslverr);
  c_stamp: cover property (rw_out.stamp_all);
endmodule : pfs_flow_cfg_sva
bind pfs_flow_cfg pfs_flow_cfg_sva chk_u (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pready(pready), .pslverr(pslverr),
  .pkt_eval(pkt_eval), .egress(egress), .frame_ofs(frame_ofs),
  .stage2_hit(stage2_hit), .rw_out(rw_out), .sig_valid(sig_valid));
`default_nettype wire

//--- verification/pfs_rw_sink.sv
// rewriter and stamp store model: takes directives and signatures
`timescale 1ns/1ps
`default_nettype none
module pfs_rw_sink
  import pfs_pkg::*;
(
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire pfs_rw_s           rw_out,
  input  wire logic [NSIG*8-1:0] sig_out,
  input  wire logic              sig_valid,
  output pfs_rw_s                last_rw,
  output logic [NSIG*8-1:0]      last_sig,
  output int                     n_sig
);
  // latch directive on hit, signature on store
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      last_rw <= '0;
      last_sig <= '0;
      n_sig <= 0;
    end else begin
      if (rw_out.hit) last_rw <= rw_out;
      if (sig_valid) last_sig <= sig_out;
      if (sig_valid) n_sig <= n_sig + 1;
    end
  end
endmodule : pfs_rw_sink
`default_nettype wire

//--- verification/testbench.sv
// self-checking bench for the flow config and signature block
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import pfs_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic pkt_busy = 0, pkt_eval = 0, pkt_chan = 0, egress = 0, part_b = 0;
  logic [AW-1:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata;
  logic pready, pslverr, sig_valid, st_seen;
  logic [NF-1:0] stage1_hit = '0, stage2_hit = '0;
  logic [1:0] prev_grp = '0;
  logic [7:0] frame_ofs = '0, av = 8'h5A, fo = 8'h0E;
  logic [NHDR*8-1:0] hdr_bytes = '0;
  logic [47:0] e1s, e1d, e2s, e2d;
  logic [63:0] i1s, i1d, i2s, i2d;
  logic [NSIG*8-1:0] sig_out, last_sig;
  pfs_rw_s rw_out, last_rw, xr;
  int err_total = 0, num_checks = 0, cyc = 0, n_sig;
  // address byte k of source i carries av xor {i,k}
  function automatic logic [63:0] mk(input logic [7:0] v, input int i);
    for (int k = 0; k < 8; k++) mk[8*k+:8] = v ^ 8'(i * 8 + k);
  endfunction : mk
  assign e1s = 48'(mk(av, 0));
  assign e1d = 48'(mk(av, 1));
  assign e2s = 48'(mk(av, 2));
  assign e2d = 48'(mk(av, 3));
  assign i1s = mk(av, 4);
  assign i1d = mk(av, 5);
  assign i2s = mk(av, 6);
  assign i2d = mk(av, 7);
  pfs_flow_cfg #(.OAM_ENGINE(1'b1)) dut_u (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pkt_busy(pkt_busy), .pkt_eval(pkt_eval), .pkt_chan(pkt_chan),
    .egress(egress), .part_b(part_b), .stage1_hit(stage1_hit),
    .stage2_hit(stage2_hit), .prev_grp(prev_grp), .frame_ofs(frame_ofs),
    .hdr_bytes(hdr_bytes), .first_ethernet_comparator_sa(e1s), .first_ethernet_comparator_da(e1d), .second_ethernet_comparator_sa(e2s),
    .second_ethernet_comparator_da(e2d), .ip1_sa(i1s), .ip1_da(i1d), .ip2_sa(i2s), .ip2_da(i2d),
    .rw_out(rw_out), .sig_out(sig_out), .sig_valid(sig_valid));
  pfs_rw_sink sink_u (.pclk(pclk), .presetn(presetn), .rw_out(rw_out),
    .sig_out(sig_out), .sig_valid(sig_valid), .last_rw(last_rw),
    .last_sig(last_sig), .n_sig(n_sig));
  // 10 MHz clock
  initial forever #50 pclk = ~pclk;
  task automatic close_out;
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : close_out
  // hang guard
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 5000) begin
      err_total++;
      close_out();
    end
  end
  task automatic chk(input string nm, input logic [127:0] s, x);
    num_checks++;
    if (s !== x) begin
      err_total++;
      $display("wrong value %s exp %h seen %h", nm, x, s);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d, output logic [31:0] q,
                     output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // wait for pready; only the bench timeout ends a hang
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
  endtask : wr
  task automatic rdc(input logic [11:0] a, input logic [31:0] x);
    logic [31:0] q;
    logic e;
    apb(1'b0, a, 32'h0, q, e);
    chk("read", {e, q}, {1'b0, x});
  endtask : rdc
  // engine off before a shared control change
  task automatic set_ctrl(input logic [31:0] v);
    wr(OFS_CTRL, 32'h0);
    wr(OFS_CTRL, v);
  endtask : set_ctrl
  // one evaluated frame, then the hit pulse is compared
  task automatic frm(input logic c, b, e, input logic [1:0] g,
                     input logic [7:0] h, input logic x);
    @(posedge pclk);
    pkt_eval <= 1'b1;
    pkt_chan <= c;
    part_b <= b;
    egress <= e;
    prev_grp <= g;
    stage1_hit <= h;
    stage2_hit <= h;
    frame_ofs <= fo;
    @(posedge pclk);
    pkt_eval <= 1'b0;
    #1;
    st_seen = rw_out.stamp_all;
    chk("hit", rw_out.hit, x);
    // let the sink latch the pulse before its copies are compared
    @(posedge pclk);
    #1;
  endtask : frm
  // expected signature for address source s and part b flag
  function automatic logic [127:0] exs(input logic [1:0] s, input logic b);
    logic [63:0] a;
    a = mk(av, 2 * s + s[0]);
    if (s < 2) a[63:48] = '0;
    if (b && s == 1) a = '0;
    return {{8{8'h5F}}, a[63:56], 32'h4440_5F00, 16'h4648, a[7:0]};
  endfunction : exs
  // main sequence
  initial begin
    logic [31:0] q;
    logic e;
    int i;
    for (i = 0; i < NHDR; i++) hdr_bytes[8*i+:8] = 8'h40 + 8'(i);
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    rdc(OFS_CTRL, CTRL_RST);
    rdc(OFS_STAGE, STAGE_RST);
    rdc(OFS_FLOW0 + 12'h8, FLOW_RST);
    rdc(OFS_MAP0, {4{2'b00, MAP_RST}});
    apb(1'b0, 12'hFFC, 32'h0, q, e);
    chk("unmapped", {e, q}, 33'h1_0000_0000);
    apb(1'b1, 12'h021, 32'hFFFF_FFFF, q, e);
    chk("unaligned", e, 1'b1);
    set_ctrl(32'h299);
    wr(OFS_STAGE, 32'hFF);
    wr(OFS_FLOW0 + 12'h8, 32'h0D08_2C8D);
    wr(OFS_FLOW0 + 12'hC, 32'h1E20_1040);
    wr(OFS_MAP0, 32'h1B18_171C);
    wr(OFS_MAP0 + 12'h4, 32'h2319_1A00);
    rdc(OFS_FLOW0 + 12'h8, 32'h0D08_2C8D);
    xr = '{hit: 1'b1, stamp_all: 1'b0, flow: 3'd2, mod_ofs: 9'h013,
           mod_pos: 3'd5, upd: 1'b1, rw_cnt: 4'h8, rw_pos: 8'h2C,
           cf_loc: 8'h08, cksum_sel: 1'b1};
    frm(0, 0, 1, 2'b01, 8'h04, 1);
    chk("rw", last_rw, xr);
    chk("sig", last_sig, exs(0, 0));
    frm(1, 0, 1, 2'b01, 8'h04, 0);
    frm(0, 0, 1, 2'b10, 8'h04, 0);
    frm(1, 0, 1, 2'b10, 8'h0C, 1);
    chk("flow", last_rw.flow, 3'd3);
    i = n_sig;
    frm(0, 0, 0, 2'b01, 8'h0C, 1);
    chk("flow", last_rw.flow, 3'd2);
    chk("sig count", n_sig, i);
    for (i = 0; i < 4; i++) begin
      @(posedge pclk);
      av <= 8'h5A + 8'(i);
      set_ctrl(32'h299 | (i << 1));
      frm(0, 0, 1, 2'b01, 8'h04, 1);
      chk("sig", last_sig, exs(2'(i), 0));
    end
    set_ctrl(32'h29B);
    frm(0, 1, 1, 2'b01, 8'h04, 1);
    chk("sig", last_sig, exs(1, 1));
    @(posedge pclk);
    pkt_busy <= 1'b1;
    wr(OFS_FLOW0 + 12'h8, 32'h0908_2C8D);
    frm(0, 0, 1, 2'b01, 8'h04, 1);
    @(posedge pclk);
    pkt_busy <= 1'b0;
    repeat (2) @(posedge pclk);
    frm(0, 0, 1, 2'b01, 8'h04, 0);
    wr(OFS_FLOW0 + 12'h8, 32'h0D08_2C8D);
    set_ctrl(32'h2B8);
    wr(OFS_STAGE, 32'hFB);
    frm(0, 0, 1, 2'b01, 8'h04, 0);
    wr(OFS_STAGE, 32'hFF);
    frm(0, 0, 1, 2'b01, 8'h04, 1);
    chk("cksum", last_rw.cksum_sel, 1'b0);
    rdc(OFS_STATUS, 32'h0000_010C);
    set_ctrl(32'h289);
    frm(0, 0, 1, 2'b00, 8'h00, 0);
    chk("stamp", st_seen, 1'b1);
    close_out();
  end
endmodule : testbench
`default_nettype wire
